// File: core/sfecp_pkg.sv
// package: constants for the serial flash erase/config programming controller
package sfecp_pkg;
    // ****************************************
    // software-facing register map (word index)
    // ****************************************
    localparam int         ADDR_W          = 4;
    localparam logic [3:0] REG_CTRL        = 4'h0;
    localparam logic [3:0] REG_INSTR       = 4'h1;
    localparam logic [3:0] REG_STATUS      = 4'h2;
    localparam logic [3:0] REG_RDATA       = 4'h3;
    localparam logic [3:0] REG_DIV         = 4'h4;
    localparam int         CTRL_START_BIT  = 0;
    localparam int         CTRL_KIND_BIT   = 1;
    localparam int         STAT_BUSY_BIT   = 0;
    localparam int         STAT_DONE_BIT   = 1;
    localparam int         STAT_GOCLR_BIT  = 2;
    localparam logic [7:0] DIV_RESET       = 8'h04;
    localparam logic [7:0] DIV_MIN         = 8'h04;
    // ****************************************
    // serial transfer shape
    // ****************************************
    localparam int         CMD_BITS        = 4;
    localparam int         INSTR_BITS      = 24;
    localparam int         IDLE_CLOCKS     = 8;
    localparam int         READ_BITS       = 16;
    localparam logic [3:0] EXECUTE_INSTRUCTION_COMMAND = 4'h0;
    localparam logic [3:0] SHIFT_OUT_COMMAND           = 4'h1;
    // ****************************************
    // device map, used by software sequences
    // ****************************************
    localparam int          MEMCTL_GO_BIT       = 15;
    localparam logic [15:0] MEMCTL_CHIP_ERASE   = 16'h404f;
    localparam logic [15:0] MEMCTL_PAGE_ERASE   = 16'h4042;
    localparam logic [15:0] MEMCTL_CFG_WRITE    = 16'h4003;
    localparam logic [15:0] MEMCTL_ROW_WRITE    = 16'h4001;
    localparam logic [7:0]  PAGE_CFG_SPACE      = 8'h80;
    localparam logic [7:0]  PAGE_CFG_SMALL      = 8'h00;
    localparam logic [7:0]  PAGE_CFG_LARGE      = 8'h01;
    localparam logic [23:0] OSC_CAL_WORD_ADDR   = 24'h0807fe;
    localparam logic [15:0] SHIFT_OUT_HOLDING   = 16'h0784;
    localparam logic [15:0] CONFIG_FIRST_RESET  = 16'h7fff;
    localparam logic [15:0] CONFIG_SECOND_RESET = 16'hffff;
    localparam logic [23:0] INSTR_JUMP_RESET    = 24'h040200;
    localparam logic [23:0] INSTR_NOP           = 24'h000000;
    // ****************************************
    // controller states
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_CMD   = 5'b00010,
        ST_INSTR = 5'b00100,
        ST_WAIT  = 5'b01000,
        ST_READ  = 5'b10000
    } sfecp_state_type;
endpackage

// File: core/sfecp_tick_if.sv
// interface: half-period tick between controller and clock divider
`timescale 1ns/100ps
interface sfecp_tick_if #(parameter int DIV_W = 8);
    logic             run;
    logic [DIV_W-1:0] half_period;
    logic             tick;
    modport gen (input run, input half_period, output tick);
    modport use_tick (output run, output half_period, input tick);
endinterface

// File: core/sfecp_tick_gen.sv
// module: divider making one-cycle half-period ticks for the programming clock
`timescale 1ns/100ps
module sfecp_tick_gen #(
    parameter int DIV_W = 8
) (
    input  wire logic   clk_sys,
    input  wire logic   srst,
    sfecp_tick_if.gen   tk
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic             tick_nxt;
    logic             tick_r;

    if (DIV_W < 3) begin : g_div_w_bad
        $error("sfecp_tick_gen: DIV_W must be at least 3");
    end

    always_comb begin
        cnt_nxt  = cnt_r + 1'b1;
        tick_nxt = 1'b0;
        if (!tk.run) begin
            cnt_nxt = '0;
        end else if (cnt_r >= tk.half_period - 1'b1) begin
            cnt_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tk.tick = tick_r;
endmodule

// File: core/sfecp_host.sv
// module: host-side serial programming port controller
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module sfecp_host #(
    parameter int DIV_W = 8
) (
    clk_sys,
    srst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    prog_clk_o,
    prog_data_i,
    prog_data_o,
    prog_data_oe
);
    import sfecp_pkg::*;
    input  wire logic                         clk_sys;
    input  wire logic                         srst;
    input  wire logic [sfecp_pkg::ADDR_W-1:0] reg_addr;
    input  wire logic [31:0]                  reg_wdata;
    input  wire logic                         reg_wr;
    input  wire logic                         reg_rd;
    output logic      [31:0]                  reg_rdata;
    output logic                              prog_clk_o;
    input  wire logic                         prog_data_i;
    output logic                              prog_data_o;
    output logic                              prog_data_oe;

    // ****************************************
    // state
    // ****************************************
    sfecp_state_type  state_r, state_nxt;
    logic [27:0]      shift_r, shift_nxt;
    logic [4:0]       cnt_r, cnt_nxt;
    logic             phase_r, phase_nxt;
    logic [15:0]      rxd_r, rxd_nxt;
    logic [15:0]      rdata_r, rdata_nxt;
    logic [23:0]      instr_r, instr_nxt;
    logic [DIV_W-1:0] div_r, div_nxt;
    logic             done_r, done_nxt;
    logic             oe_r, oe_nxt;
    logic [31:0]      rd_r, rd_nxt;
    logic             din_meta_r, din_sync_r;
    logic             start;
    logic             kind;

    sfecp_tick_if #(.DIV_W(DIV_W)) tk ();

    sfecp_tick_gen #(.DIV_W(DIV_W)) u_tick (
        .clk_sys (clk_sys),
        .srst    (srst),
        .tk      (tk)
    );

    // the divider read-back pads into a 32-bit word
    if (DIV_W < 3 || DIV_W > 32) begin : g_div_w_bad
        $error("sfecp_host: DIV_W must be between 3 and 32");
    end

    assign tk.run         = (state_r != ST_IDLE);
    assign tk.half_period = div_r;
    assign start = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_START_BIT];
    assign kind  = reg_wdata[CTRL_KIND_BIT];

    // ****************************************
    // pin input synchroniser
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            din_meta_r <= 1'b0;
            din_sync_r <= 1'b0;
        end else begin
            din_meta_r <= prog_data_i;
            din_sync_r <= din_meta_r;
        end
    end

    // ****************************************
    // registers and serial engine
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt   = cnt_r;
        phase_nxt = phase_r;
        rxd_nxt   = rxd_r;
        rdata_nxt = rdata_r;
        instr_nxt = instr_r;
        div_nxt   = div_r;
        done_nxt  = done_r;
        oe_nxt    = oe_r;
        rd_nxt    = 32'h0000_0000;
        if (reg_wr && reg_addr == REG_INSTR) begin
            instr_nxt = reg_wdata[23:0];
        end
        if (reg_wr && reg_addr == REG_DIV) begin
            // too short a half period would outrun the input synchroniser
            div_nxt = (reg_wdata[DIV_W-1:0] < DIV_W'(DIV_MIN)) ?
                      DIV_W'(DIV_MIN) : reg_wdata[DIV_W-1:0];
        end
        if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_DONE_BIT]) begin
            done_nxt = 1'b0;
        end
        case (state_r)
            ST_IDLE: begin
                phase_nxt = 1'b0;
                cnt_nxt   = 5'h00;
                // starts while busy are dropped: engine only listens here
                if (start) begin
                    oe_nxt = 1'b1;
                    if (kind) begin
                        shift_nxt = {24'h000000, SHIFT_OUT_COMMAND};
                    end else begin
                        shift_nxt = {instr_r, EXECUTE_INSTRUCTION_COMMAND};
                    end
                    rxd_nxt   = 16'h0000;
                    state_nxt = kind ? ST_CMD : ST_INSTR;
                    // execute transfers count all 28 bits in one state
                    cnt_nxt   = kind ? 5'h00 : 5'h00;
                end
            end
            ST_CMD, ST_INSTR, ST_WAIT, ST_READ: begin
                if (tk.tick) begin
                    if (!phase_r) begin
                        phase_nxt = 1'b1;
                        if (state_r == ST_READ) begin
                            rxd_nxt = {din_sync_r, rxd_r[15:1]};
                        end
                    end else begin
                        phase_nxt = 1'b0;
                        cnt_nxt   = cnt_r + 5'h01;
                        shift_nxt = {1'b0, shift_r[27:1]};
                        case (state_r)
                            ST_CMD: begin
                                if (cnt_r == 5'(CMD_BITS - 1)) begin
                                    // release the pin before the device turns it round
                                    oe_nxt    = 1'b0;
                                    cnt_nxt   = 5'h00;
                                    state_nxt = ST_WAIT;
                                end
                            end
                            ST_INSTR: begin
                                if (cnt_r == 5'(CMD_BITS + INSTR_BITS - 1)) begin
                                    oe_nxt    = 1'b0;
                                    done_nxt  = 1'b1;
                                    state_nxt = ST_IDLE;
                                end
                            end
                            ST_WAIT: begin
                                if (cnt_r == 5'(IDLE_CLOCKS - 1)) begin
                                    cnt_nxt   = 5'h00;
                                    state_nxt = ST_READ;
                                end
                            end
                            ST_READ: begin
                                if (cnt_r == 5'(READ_BITS - 1)) begin
                                    rdata_nxt = rxd_r;
                                    done_nxt  = 1'b1;
                                    state_nxt = ST_IDLE;
                                end
                            end
                            default: begin
                                state_nxt = ST_IDLE;
                            end
                        endcase
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                oe_nxt    = 1'b0;
            end
        endcase
        if (reg_rd) begin
            case (reg_addr)
                REG_INSTR:  rd_nxt = {8'h00, instr_r};
                REG_STATUS: begin
                    rd_nxt[STAT_BUSY_BIT]  = (state_r != ST_IDLE);
                    rd_nxt[STAT_DONE_BIT]  = done_r;
                    rd_nxt[STAT_GOCLR_BIT] = ~rdata_r[MEMCTL_GO_BIT];
                end
                REG_RDATA:  rd_nxt = {16'h0000, rdata_r};
                REG_DIV:    rd_nxt = {{(32-DIV_W){1'b0}}, div_r};
                default:    rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= ST_IDLE;
            shift_r <= 28'h0000000;
            cnt_r   <= 5'h00;
            phase_r <= 1'b0;
            rxd_r   <= 16'h0000;
            rdata_r <= 16'h0000;
            instr_r <= 24'h000000;
            div_r   <= DIV_W'(DIV_RESET);
            done_r  <= 1'b0;
            oe_r    <= 1'b0;
            rd_r    <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cnt_r   <= cnt_nxt;
            phase_r <= phase_nxt;
            rxd_r   <= rxd_nxt;
            rdata_r <= rdata_nxt;
            instr_r <= instr_nxt;
            div_r   <= div_nxt;
            done_r  <= done_nxt;
            oe_r    <= oe_nxt;
            rd_r    <= rd_nxt;
        end
    end

    assign reg_rdata    = rd_r;
    assign prog_clk_o   = phase_r;
    assign prog_data_o  = shift_r[0];
    assign prog_data_oe = oe_r;

    // ****************************************
    // checks
    // ****************************************
    chk_idle_quiet: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == ST_IDLE) |-> (!prog_clk_o && !prog_data_oe))
        else $error("pins not quiet while idle");

    chk_data_hold_high: assert property (@(posedge clk_sys) disable iff (srst)
        (prog_clk_o && $past(prog_clk_o)) |-> $stable(prog_data_o))
        else $error("data changed while programming clock high");

    chk_exec_lsb_first: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == ST_IDLE && start && !kind) |=>
        (prog_data_oe && prog_data_o == EXECUTE_INSTRUCTION_COMMAND[0]
         && state_r == ST_INSTR))
        else $error("execute transfer did not start with command lsb");

    chk_shiftout_code: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == ST_IDLE && start && kind) |=>
        (prog_data_oe && prog_data_o && state_r == ST_CMD))
        else $error("shift-out command lsb not driven");

    chk_read_released: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == ST_WAIT || state_r == ST_READ) |-> !prog_data_oe)
        else $error("data pin driven during turnaround or read");

    chk_wait_count: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == ST_WAIT) |-> (cnt_r < 5'(IDLE_CLOCKS)))
        else $error("idle clock count overran");

    chk_read_done: assert property (@(posedge clk_sys) disable iff (srst)
        (state_r == ST_READ && tk.tick && phase_r && cnt_r == 5'(READ_BITS - 1)) |=>
        (done_r && rdata_r == $past(rxd_r) && state_r == ST_IDLE))
        else $error("read word not captured at end of sixteen clocks");

    chk_rdata_upper: assert property (@(posedge clk_sys) disable iff (srst)
        (reg_rd && reg_addr == REG_RDATA) |=>
        (reg_rdata[31:16] == 16'h0000 && reg_rdata[15:0] == $past(rdata_r)))
        else $error("read data upper half not zero");

    chk_goclr_flag: assert property (@(posedge clk_sys) disable iff (srst)
        (reg_rd && reg_addr == REG_STATUS) |=>
        (reg_rdata[STAT_GOCLR_BIT] == ~$past(rdata_r[MEMCTL_GO_BIT])))
        else $error("go-clear status wrong");
endmodule

// File: tb/sfecp_dev_model.sv
// device model: flash device behind the serial programming port
`timescale 1ns/100ps
module sfecp_dev_model #(
    parameter logic [23:0] FIRST_ADDR = 24'h00abfe,
    parameter logic [15:0] CAL_VAL    = 16'h3c5a,
    parameter logic [23:0] INS_CTL_LD = 24'h8800a0,
    parameter logic [23:0] INS_CTL_RD = 24'h8800b0,
    parameter logic [23:0] INS_TBLWT  = 24'h8800c0,
    parameter int          CYCLE_NS   = 12000
) (
    input  wire logic pclk,
    input  wire logic pin,
    input  wire logic dev_rst,
    output logic      dev_o,
    output logic      dev_oe
);
    import sfecp_pkg::*;
    // ****************************************
    // device registers
    // ****************************************
    logic [15:0] w [16];
    logic [15:0] memctl, holding, cal, wr_data;
    logic [15:0] flash [2];
    logic [15:0] cfg_reg [2];
    logic [7:0]  tbl_page, erase_pag;
    logic [23:0] wr_addr;
    logic [27:0] sh, last_frame;
    logic        out_mode, hold_pin;
    int          cnt, frames;
    event        go_ev;
    initial begin
        flash[0] = CONFIG_FIRST_RESET;
        flash[1] = CONFIG_SECOND_RESET;
        cfg_reg = flash;
        {memctl, holding, tbl_page, erase_pag, sh} = '0;
        {out_mode, hold_pin, dev_o, dev_oe} = '0;
        cal = CAL_VAL;
        cnt = 0;
        frames = 0;
    end
    always @(posedge dev_rst) cfg_reg = flash;
    function automatic logic [15:0] rd16(input logic [23:0] a);
        if (a == FIRST_ADDR) return flash[0];
        if (a == FIRST_ADDR - 24'h2) return flash[1];
        if (a == OSC_CAL_WORD_ADDR) return cal;
        return 16'h0;
    endfunction
    task automatic run_instr(input logic [23:0] i);
        if (i[23:20] == 4'h2) w[i[3:0]] = i[19:4];
        else if (i == 24'h880190) tbl_page = w[0][7:0];
        else if (i == 24'hba0bb6) begin
            if (w[7] == SHIFT_OUT_HOLDING) holding = rd16({tbl_page, w[6]});
            w[6] = w[6] + 16'h2;
        end else if (i == INS_TBLWT) begin
            erase_pag = tbl_page;
            wr_addr = {tbl_page, w[7]};
            wr_data = w[0];
        end else if (i == INS_CTL_RD) holding = memctl;
        else if (i == INS_CTL_LD && !memctl[MEMCTL_GO_BIT]) begin
            memctl = w[0];
            if (w[0][MEMCTL_GO_BIT]) ->go_ev;
        end
    endtask
    // ****************************************
    // self-timed cycle, no outside timing
    // ****************************************
    always begin
        @go_ev;
        #(CYCLE_NS);
        if (memctl[14:0] == MEMCTL_CHIP_ERASE[14:0] && erase_pag >= PAGE_CFG_SPACE) begin
            flash[0] = CONFIG_FIRST_RESET;
            flash[1] = CONFIG_SECOND_RESET;
            cal = 16'hffff;
        end else if (memctl[14:0] == MEMCTL_CFG_WRITE[14:0]) begin
            if (wr_addr == FIRST_ADDR) flash[0] &= wr_data;
            if (wr_addr == FIRST_ADDR - 24'h2) flash[1] &= wr_data;
        end
        memctl[MEMCTL_GO_BIT] = 1'b0;
    end
    // ****************************************
    // serial port
    // ****************************************
    always @(posedge pclk) begin
        if (hold_pin) begin
            hold_pin = 1'b0;
            dev_oe = 1'b0;
            dev_o = ~dev_o;
        end
        cnt = cnt + 1;
        if (out_mode) begin
            if (cnt == IDLE_CLOCKS + READ_BITS) begin
                out_mode = 1'b0;
                cnt = 0;
                hold_pin = 1'b1;
            end
        end else begin
            sh = {pin, sh[27:1]};
            if (cnt == CMD_BITS && sh[27:24] == SHIFT_OUT_COMMAND) begin
                out_mode = 1'b1;
                cnt = 0;
            end else if (cnt == CMD_BITS + INSTR_BITS) begin
                last_frame = sh;
                frames++;
                cnt = 0;
                run_instr(sh[27:4]);
            end
        end
    end
    always @(negedge pclk) begin
        if (out_mode && cnt >= IDLE_CLOCKS) begin
            dev_oe = 1'b1;
            dev_o = holding[cnt-IDLE_CLOCKS];
        end
    end
endmodule

// File: tb/tb_top.sv
// testbench: register-level tests of the serial programming controller
`timescale 1ns/100ps
module tb_top;
    import sfecp_pkg::*;
    localparam logic [23:0] CTL_LD = 24'h8800a0;
    localparam logic [23:0] CTL_RD = 24'h8800b0;
    localparam logic [23:0] TBLWT  = 24'h8800c0;
    localparam logic [15:0] SEC_LO = 16'habfc;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        dev_rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, v;
    logic        prog_clk_o, prog_data_o, prog_data_oe, dev_o, pin;
    logic        pclk_q = 1'b0;
    logic        pdat_q = 1'b0;
    logic        oe_q = 1'b0;
    logic [7:0]  div_exp = 8'h04;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          hi_cnt = 0;
    assign pin = prog_data_oe ? prog_data_o : dev_o;
    always #10 clk_sys = ~clk_sys;
    sfecp_host #(.DIV_W(8)) uut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .prog_clk_o(prog_clk_o), .prog_data_i(pin), .prog_data_o(prog_data_o),
        .prog_data_oe(prog_data_oe));
    sfecp_dev_model #(.INS_CTL_LD(CTL_LD), .INS_CTL_RD(CTL_RD), .INS_TBLWT(TBLWT)) dev (
        .pclk(prog_clk_o), .pin(pin), .dev_rst(dev_rst), .dev_o(dev_o), .dev_oe());
    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic wait_done();
        logic [31:0] s;
        s = '0;
        for (int k = 0; k < 400 && s[STAT_DONE_BIT] !== 1'b1; k++) rd(REG_STATUS, s);
        chk("done", 32'h1, {31'h0, s[STAT_DONE_BIT]});
        wr(REG_STATUS, 32'h2);
    endtask
    task automatic ex(input logic [23:0] i);
        wr(REG_INSTR, {8'h0, i});
        wr(REG_CTRL, 32'h1);
        wait_done();
    endtask
    task automatic so(output logic [31:0] d);
        wr(REG_CTRL, 32'h3);
        wait_done();
        rd(REG_RDATA, d);
    endtask
    task automatic tbl_out(input logic [15:0] exp);
        logic [31:0] s;
        ex(24'hba0bb6);
        ex(INSTR_NOP);
        ex(INSTR_NOP);
        so(v);
        chk("read word", {16'h0, exp}, v);
        rd(REG_STATUS, s);
        chk("go clear flag", {31'h0, ~exp[15]}, {31'h0, s[STAT_GOCLR_BIT]});
    endtask
    task automatic read_word(input logic [7:0] pg, input logic [15:0] a, input logic [15:0] exp);
        ex({12'h200, pg, 4'h0});
        ex(24'h880190);
        ex({4'h2, a, 4'h6});
        ex({4'h2, SHIFT_OUT_HOLDING, 4'h7});
        ex(INSTR_NOP);
        tbl_out(exp);
    endtask
    task automatic run_cycle(input logic [15:0] ctl);
        logic [31:0] s;
        s = '0;
        ex({4'h2, ctl, 4'h0});
        ex(CTL_LD);
        for (int k = 0; k < 20 && s[STAT_GOCLR_BIT] !== 1'b1; k++) begin
            ex(CTL_RD);
            so(v);
            rd(REG_STATUS, s);
            if (k == 0) chk("go held", 32'h0, {31'h0, s[STAT_GOCLR_BIT]});
        end
        chk("go cleared", 32'h1, {31'h0, s[STAT_GOCLR_BIT]});
    endtask
    task automatic set_page(input logic [7:0] pg);
        ex({12'h200, pg, 4'h0});
        ex(24'h880190);
        ex(TBLWT);
    endtask
    task automatic prog_word(input logic [15:0] a, input logic [15:0] d);
        ex({4'h2, MEMCTL_CFG_WRITE, 4'h0});
        ex(CTL_LD);
        ex({12'h200, PAGE_CFG_SMALL, 4'h0});
        ex(24'h880190);
        ex({4'h2, a, 4'h7});
        ex({4'h2, d, 4'h0});
        ex(TBLWT);
        run_cycle(MEMCTL_CFG_WRITE | 16'h8000);
    endtask
    // ****************************************
    // pin watch and hang limit
    // ****************************************
    always @(negedge clk_sys) begin
        cyc++;
        if (oe_q && prog_data_oe && prog_data_o !== pdat_q)
            chk("data edge", 32'h1, {31'h0, pclk_q & ~prog_clk_o});
        if (prog_clk_o) hi_cnt++;
        else if (pclk_q) begin
            chk("clock high", {24'h0, div_exp}, 32'(hi_cnt));
            hi_cnt = 0;
        end
        pclk_q = prog_clk_o;
        pdat_q = prog_data_o;
        oe_q = prog_data_oe;
        // hang limit: well above the length of the whole sequence
        if (cyc == 90000) begin
            num_errors++;
            results();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        dev_rst <= 1'b0;
        rd(REG_STATUS, v);
        chk("status reset", 32'h4, v);
        rd(REG_DIV, v);
        chk("div reset", {24'h0, DIV_RESET}, v);
        rd(4'hf, v);
        chk("unmapped", 32'h0, v);
        wr(REG_INSTR, 32'hffa5c3e1);
        rd(REG_INSTR, v);
        chk("instr", 32'h00a5c3e1, v);
        ex(24'ha5c3e1);
        chk("frame", {4'h0, 24'ha5c3e1, 4'h0}, {4'h0, dev.last_frame});
        wr(REG_CTRL, 32'h1);
        wr(REG_CTRL, 32'h1);
        wait_done();
        rd(REG_STATUS, v);
        chk("no restart", 32'h0, {31'h0, v[STAT_BUSY_BIT]});
        wr(REG_DIV, 32'h6);
        div_exp = 8'h06;
        ex(INSTR_NOP);
        wr(REG_DIV, 32'h2);
        div_exp = 8'h04;
        rd(REG_DIV, v);
        chk("div floor", 32'h4, v);
        ex(INSTR_NOP);
        ex(INSTR_JUMP_RESET);
        ex(INSTR_NOP);
        read_word(PAGE_CFG_SMALL, SEC_LO, CONFIG_SECOND_RESET);
        tbl_out(CONFIG_FIRST_RESET);
        ex(INSTR_JUMP_RESET);
        ex(INSTR_NOP);
        prog_word(SEC_LO, 16'h0f0f);
        prog_word(SEC_LO, 16'hf0ff);
        read_word(PAGE_CFG_SMALL, SEC_LO, 16'h000f);
        set_page(8'h00);
        run_cycle(MEMCTL_CHIP_ERASE | 16'h8000);
        read_word(PAGE_CFG_SMALL, SEC_LO, 16'h000f);
        read_word(OSC_CAL_WORD_ADDR[23:16], OSC_CAL_WORD_ADDR[15:0], 16'h3c5a);
        set_page(PAGE_CFG_SPACE);
        run_cycle(MEMCTL_CHIP_ERASE | 16'h8000);
        read_word(PAGE_CFG_SMALL, SEC_LO, CONFIG_SECOND_RESET);
        tbl_out(CONFIG_FIRST_RESET);
        read_word(OSC_CAL_WORD_ADDR[23:16], OSC_CAL_WORD_ADDR[15:0], 16'hffff);
        results();
    end
endmodule
